// [rtl/ptm_timer.sv]
`include "ptm_map.svh"
// Function
// - ten-bit up-counter, two full-width comparators
// - count readable only, never software-written
// - auto clear on overflow or match, flag
// - hold bit freezes count, resume after
// - clock select picks divided, sub or pin
// - run rise zeroes count, fall keeps it
// - run rise restores initial output level in compare mode
// - mode field selects mode; timer disables pin
// - match A: keep, low, high, toggle
// - pwm fn: inactive, active, pwm, single
// - capture edge: rise, fall, both, off
// - requested level equal initial shows nothing
// - initial level bit sets level or polarity
// - invert bit inverts pin, not timer mode
// - capture source: capture pin or clock pin
// - clear select zero clears on period match, except in single pulse
// - unimplemented bits read back as zero
// - clear select one clears on match A in compare and timer modes
// - matches set flags; no P flag then
// - compare mode pin moves only on A or run rise
module ptm_timer (
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire ptm_pkg::ptm_bus_req_type bus_req,
  output logic [7:0]                    bus_rdata,
  input  wire logic                     sub_clk_pin,
  input  wire logic                     ext_clock_pin,
  input  wire logic                     capture_input_pin,
  output logic                          timer_output_pin,
  output logic                          timer_output_complement,
  output logic                          timer_output_oe,
  output logic                          match_a_flag,
  output logic                          match_p_flag
);
  // ========================================================
  // registers and state
  ptm_pkg::ptm_ctrl0_type ctrl0_r;      // hold, clock select, run
  ptm_pkg::ptm_ctrl1_type ctrl1_r;      // mode and pin control
  logic [9:0]             cnt_r;        // the counter itself
  logic [9:0]             cmpa_r;       // committed compare A
  logic [9:0]             per_r;        // committed period compare
  logic [7:0]             cmpa_lo_r;    // low byte waiting for high
  logic [7:0]             per_lo_r;     // low byte waiting for high
  logic [1:0]             flags_r;      // sticky match flags
  logic                   run_prev_r;   // run bit one cycle ago
  logic                   out_lvl_r;    // output level before invert
  logic [5:0]             pre_r;        // free running prescaler
  logic [2:0]             ext_sync_r;   // ext pin sync plus history
  logic [2:0]             cap_sync_r;   // capture pin sync plus history
  logic [2:0]             sub_sync_r;   // sub clock sync plus history
  logic [7:0]             rdata_r;      // read data, one cycle late

  // upper byte of a 10-bit value, top six bits zero
  function automatic logic [7:0] hi_byte(input logic [9:0] v);
    hi_byte = {6'h00, v[9:8]};
  endfunction

  // ========================================================
  // bus decode
  logic wr_ctrl0, wr_ctrl1, wr_a_lo, wr_a_hi, wr_p_lo, wr_p_hi, wr_stat;
  assign wr_ctrl0 = bus_req.wr && (bus_req.addr == `PTM_OFF_CTRL0);
  assign wr_ctrl1 = bus_req.wr && (bus_req.addr == `PTM_OFF_CTRL1);
  assign wr_a_lo  = bus_req.wr && (bus_req.addr == `PTM_OFF_CMPA_LO);
  assign wr_a_hi  = bus_req.wr && (bus_req.addr == `PTM_OFF_CMPA_HI);
  assign wr_p_lo  = bus_req.wr && (bus_req.addr == `PTM_OFF_PER_LO);
  assign wr_p_hi  = bus_req.wr && (bus_req.addr == `PTM_OFF_PER_HI);
  assign wr_stat  = bus_req.wr && (bus_req.addr == `PTM_OFF_STATUS);

  // ========================================================
  // pin synchronisers: logic reads stages 1 and 2 only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ext_sync_r <= 3'h0;
      cap_sync_r <= 3'h0;
      sub_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_clock_pin};
      cap_sync_r <= {cap_sync_r[1:0], capture_input_pin};
      sub_sync_r <= {sub_sync_r[1:0], sub_clk_pin};
    end
  end

  // edges taken between stage 1 and history stage 2
  logic ext_rise, ext_fall, cap_rise, cap_fall, sub_rise;
  assign ext_rise = ext_sync_r[1] & ~ext_sync_r[2];
  assign ext_fall = ~ext_sync_r[1] & ext_sync_r[2];
  assign cap_rise = cap_sync_r[1] & ~cap_sync_r[2];
  assign cap_fall = ~cap_sync_r[1] & cap_sync_r[2];
  assign sub_rise = sub_sync_r[1] & ~sub_sync_r[2];

  // ========================================================
  // prescaler; the high clock is taken as the system clock
  always_ff @(posedge ref_clk) begin
    if (srst) pre_r <= 6'h00;
    else      pre_r <= pre_r + 6'h01;
  end

  // count tick from the selected source
  logic tick;
  always_comb begin
    case (ctrl0_r.count_clock_select)
      `PTM_CK_SYS_DIV4: tick = (pre_r[1:0] == `PTM_PRE_DIV4);
      `PTM_CK_SYS:      tick = 1'b1;
      `PTM_CK_H_DIV16:  tick = (pre_r[3:0] == `PTM_PRE_DIV16);
      `PTM_CK_H_DIV64:  tick = (pre_r == `PTM_PRE_DIV64);
      `PTM_CK_SUB_A,
      `PTM_CK_SUB_B:    tick = sub_rise;
      `PTM_CK_EXT_RISE: tick = ext_rise;
      `PTM_CK_EXT_FALL: tick = ext_fall;
      default:          tick = 1'b0;
    endcase
  end

  // ========================================================
  // comparators and counter events
  logic [1:0] mode;
  logic [1:0] fn;
  logic       single_mode, clear_a, run_rise, counting;
  logic [9:0] cnt_inc;
  logic       a_hit, p_end, ev_a, ev_p, cnt_clear;
  assign mode        = ctrl1_r.op_mode_select;
  assign fn          = ctrl1_r.pin_function_select;
  assign single_mode = (mode == `PTM_MODE_PWM) && (fn == `PTM_FN_11);
  // clear on A only in compare and timer modes
  assign clear_a     = ctrl1_r.clear_source_select &&
                       ((mode == `PTM_MODE_CMP) || (mode == `PTM_MODE_TMR));
  assign run_rise    = ctrl0_r.counter_run_enable & ~run_prev_r;
  // hold freezes without touching the count
  assign counting    = ctrl0_r.counter_run_enable & ~ctrl0_r.counter_hold
                       & ~run_rise & tick;
  assign cnt_inc     = cnt_r + 10'h001;
  assign a_hit       = (cnt_inc == cmpa_r);
  // zero period means clear by overflow
  assign p_end       = (per_r == `PTM_RST_VAL10) ? (cnt_r == `PTM_CNT_MAX)
                                                 : (cnt_inc == per_r);
  assign ev_a        = counting & a_hit;
  assign ev_p        = counting & p_end;
  // single pulse never clears the count by a match
  assign cnt_clear   = clear_a ? ev_a : (ev_p & ~single_mode);

  // run edge history
  always_ff @(posedge ref_clk) begin
    if (srst) run_prev_r <= 1'b0;
    else      run_prev_r <= ctrl0_r.counter_run_enable;
  end

  // counter: no software write path exists
  always_ff @(posedge ref_clk) begin
    if (srst)           cnt_r <= `PTM_RST_VAL10;
    else if (run_rise)  cnt_r <= `PTM_RST_VAL10;
    else if (cnt_clear) cnt_r <= `PTM_RST_VAL10;
    else if (counting)  cnt_r <= cnt_inc;
  end

  // ========================================================
  // capture trigger
  logic src_rise, src_fall, cap_ev;
  assign src_rise = ctrl1_r.capture_source_select ? ext_rise : cap_rise;
  assign src_fall = ctrl1_r.capture_source_select ? ext_fall : cap_fall;
  always_comb begin
    case (fn)
      `PTM_FN_00: cap_ev = src_rise;
      `PTM_FN_01: cap_ev = src_fall;
      `PTM_FN_10: cap_ev = src_rise | src_fall;
      default:    cap_ev = 1'b0;
    endcase
    cap_ev = cap_ev && (mode == `PTM_MODE_CAP) && ctrl0_r.counter_run_enable;
  end

  // ========================================================
  // control registers; single pulse also drives the run bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl0_r <= ptm_pkg::ptm_ctrl0_type'(`PTM_RST_BYTE);
      ctrl1_r <= ptm_pkg::ptm_ctrl1_type'(`PTM_RST_BYTE);
    end else begin
      if (wr_ctrl0) begin
        // unused low bits never stored, so they read back as zero
        ctrl0_r <= ptm_pkg::ptm_ctrl0_type'({bus_req.wdata[7:3], 3'h0});
      end else if (single_mode && ev_a) begin
        ctrl0_r.counter_run_enable <= 1'b0;      // pulse ends on match A
      end else if (single_mode && ext_rise) begin
        ctrl0_r.counter_run_enable <= 1'b1;      // pin edge fires the pulse
      end
      if (wr_ctrl1) ctrl1_r <= ptm_pkg::ptm_ctrl1_type'(bus_req.wdata);
    end
  end

  // ========================================================
  // compare values: low byte waits, high byte commits both
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmpa_lo_r <= `PTM_RST_BYTE;
      per_lo_r  <= `PTM_RST_BYTE;
      cmpa_r    <= `PTM_RST_VAL10;
      per_r     <= `PTM_RST_VAL10;
    end else begin
      if (wr_a_lo) cmpa_lo_r <= bus_req.wdata;
      if (wr_p_lo) per_lo_r  <= bus_req.wdata;
      // capture wins over a write landing in the same cycle
      if (cap_ev)       cmpa_r <= cnt_r;
      else if (wr_a_hi) cmpa_r <= {bus_req.wdata[1:0], cmpa_lo_r};
      if (wr_p_hi)      per_r  <= {bus_req.wdata[1:0], per_lo_r};
    end
  end

  // ========================================================
  // sticky flags, write one to clear, set beats clear
  logic set_a, set_p;
  assign set_a = (mode == `PTM_MODE_CAP) ? cap_ev : ev_a;
  assign set_p = ev_p & ~clear_a;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flags_r <= 2'h0;
    end else begin
      flags_r[`PTM_ST_FLAG_A] <= set_a |
        (flags_r[`PTM_ST_FLAG_A] & ~(wr_stat & bus_req.wdata[`PTM_ST_FLAG_A]));
      flags_r[`PTM_ST_FLAG_P] <= set_p |
        (flags_r[`PTM_ST_FLAG_P] & ~(wr_stat & bus_req.wdata[`PTM_ST_FLAG_P]));
    end
  end
  assign match_a_flag = flags_r[`PTM_ST_FLAG_A];
  assign match_p_flag = flags_r[`PTM_ST_FLAG_P];

  // ========================================================
  // output level before inversion
  logic init_lvl, pwm_act;
  assign init_lvl = ctrl1_r.output_initial_level;
  // duty at or above period gives full duty
  assign pwm_act  = (cnt_r < cmpa_r);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_lvl_r <= 1'b0;
    end else if (mode == `PTM_MODE_CMP) begin
      if (run_rise) begin
        out_lvl_r <= init_lvl;
      end else if (ev_a) begin
        case (fn)
          `PTM_FN_01: out_lvl_r <= 1'b0;
          `PTM_FN_10: out_lvl_r <= 1'b1;
          `PTM_FN_11: out_lvl_r <= ~out_lvl_r;
          default:    out_lvl_r <= out_lvl_r;
        endcase
      end
    end else if (mode == `PTM_MODE_PWM) begin
      case (fn)
        `PTM_FN_00: out_lvl_r <= ~init_lvl;
        `PTM_FN_01: out_lvl_r <= init_lvl;
        `PTM_FN_10: out_lvl_r <= pwm_act ? init_lvl : ~init_lvl;
        default:    out_lvl_r <= ctrl0_r.counter_run_enable ? init_lvl : ~init_lvl;
      endcase
    end
  end

  // pins; timer and capture modes release the pin
  assign timer_output_oe  = (mode == `PTM_MODE_CMP) || (mode == `PTM_MODE_PWM);
  assign timer_output_pin = out_lvl_r ^ ctrl1_r.output_invert;
  assign timer_output_complement = ~timer_output_pin;

  // ========================================================
  // read port, data stands one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_r <= `PTM_RST_BYTE;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `PTM_OFF_CTRL0:   rdata_r <= {ctrl0_r[7:3], 3'h0};
        `PTM_OFF_CTRL1:   rdata_r <= ctrl1_r;
        `PTM_OFF_CNT_LO:  rdata_r <= cnt_r[7:0];
        `PTM_OFF_CNT_HI:  rdata_r <= hi_byte(cnt_r);
        `PTM_OFF_CMPA_LO: rdata_r <= cmpa_r[7:0];
        `PTM_OFF_CMPA_HI: rdata_r <= hi_byte(cmpa_r);
        `PTM_OFF_PER_LO:  rdata_r <= per_r[7:0];
        `PTM_OFF_PER_HI:  rdata_r <= hi_byte(per_r);
        `PTM_OFF_STATUS:  rdata_r <= {6'h00, flags_r};
        default:          rdata_r <= `PTM_RST_BYTE;           // unmapped reads zero
      endcase
    end else begin
      rdata_r <= `PTM_RST_BYTE;
    end
  end
  assign bus_rdata = rdata_r;

  // ========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_start;
    !run_prev_r ##0 ctrl0_r.counter_run_enable;
  endsequence
  sequence s_hi_a_write;
    wr_a_hi ##0 !cap_ev;
  endsequence

  a_start_zeroes: assert property (s_start |=> cnt_r == 10'h000)
    else $error("counter not zero after run rise");
  a_hold_freeze: assert property (ctrl0_r.counter_hold && !run_rise |=> $stable(cnt_r))
    else $error("counter moved while held");
  a_period_clear: assert property (ev_p && !clear_a && !single_mode |=> cnt_r == 10'h000)
    else $error("period match did not clear");
  a_match_a_clear: assert property (ev_a && clear_a |=> cnt_r == 10'h000)
    else $error("match A did not clear");
  a_p_flag_cause: assert property ($rose(match_p_flag) |-> $past(ev_p && !clear_a))
    else $error("P flag set without cause");
  a_initial_level: assert property (s_start ##0 mode == 2'h0 |=> out_lvl_r == $past(init_lvl))
    else $error("initial level not restored");
  a_toggle_match: assert property (ev_a && !run_rise && mode == 2'h0 && fn == 2'h3
                                   |=> out_lvl_r != $past(out_lvl_r))
    else $error("toggle missing");
  a_pin_on_a_only: assert property (mode == 2'h0 && !ev_a && !run_rise |=> $stable(out_lvl_r))
    else $error("pin moved without match A");
  a_complement_pin: assert property (timer_output_complement == !timer_output_pin)
    else $error("complement not inverse");
  a_timer_no_pin: assert property (mode == 2'h3 |-> !timer_output_oe)
    else $error("pin driven in timer mode");
  a_pair_commit: assert property (s_hi_a_write |=> cmpa_r == {$past(bus_req.wdata[1:0]),
                                  $past(cmpa_lo_r)})
    else $error("compare pair not committed");
endmodule

// [common/ptm_map.svh]
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH
// ==========================================================
// register offsets (byte registers, 4-bit address)
`define PTM_OFF_CTRL0      4'h0
`define PTM_OFF_CTRL1      4'h1
`define PTM_OFF_CNT_LO     4'h2
`define PTM_OFF_CNT_HI     4'h3
`define PTM_OFF_CMPA_LO    4'h4
`define PTM_OFF_CMPA_HI    4'h5
`define PTM_OFF_PER_LO     4'h6
`define PTM_OFF_PER_HI     4'h7
`define PTM_OFF_STATUS     4'h8
// ==========================================================
// reset values
`define PTM_RST_BYTE       8'h00
`define PTM_RST_VAL10      10'h000
// ==========================================================
// field positions
`define PTM_ST_FLAG_A      0
`define PTM_ST_FLAG_P      1
// ==========================================================
// op_mode_select codes
`define PTM_MODE_CMP       2'h0
`define PTM_MODE_CAP       2'h1
`define PTM_MODE_PWM       2'h2
`define PTM_MODE_TMR       2'h3
// pin_function_select codes
`define PTM_FN_00          2'h0
`define PTM_FN_01          2'h1
`define PTM_FN_10          2'h2
`define PTM_FN_11          2'h3
// ==========================================================
// count_clock_select codes
`define PTM_CK_SYS_DIV4    3'h0
`define PTM_CK_SYS         3'h1
`define PTM_CK_H_DIV16     3'h2
`define PTM_CK_H_DIV64     3'h3
`define PTM_CK_SUB_A       3'h4
`define PTM_CK_SUB_B       3'h5
`define PTM_CK_EXT_RISE    3'h6
`define PTM_CK_EXT_FALL    3'h7
// prescaler masks for the divided clocks
`define PTM_PRE_DIV4       6'h03
`define PTM_PRE_DIV16      6'h0f
`define PTM_PRE_DIV64      6'h3f
`define PTM_CNT_MAX        10'h3ff
`endif

// [common/ptm_pkg.sv]
package ptm_pkg;
  // ========================================================
  // first control register layout
  typedef struct packed {
    logic       counter_hold;
    logic [2:0] count_clock_select;
    logic       counter_run_enable;
    logic [2:0] unused;
  } ptm_ctrl0_type;
  // second control register layout
  typedef struct packed {
    logic [1:0] op_mode_select;
    logic [1:0] pin_function_select;
    logic       output_initial_level;
    logic       output_invert;
    logic       capture_source_select;
    logic       clear_source_select;
  } ptm_ctrl1_type;
  // register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ptm_bus_req_type;
endpackage

// [sim/ptm_pin_model.sv]
// ==========
// pin side: clock pin, capture pin, sub clock
module ptm_pin_model (
  input  wire logic ref_clk,
  input  wire logic ext_req,
  input  wire logic cap_req,
  output logic      ext_clock_pin,
  output logic      capture_input_pin,
  output logic      sub_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int ext_left = 0; // high cycles left on clock pin
  int cap_left = 0; // high cycles left on capture pin
  int sub_div  = 0; // sub clock phase
  // ten-cycle pulses so both edges survive the input synchronisers
  always @(posedge ref_clk) begin
    ext_left <= ext_req ? 10 : (ext_left > 0 ? ext_left - 1 : 0);
    cap_left <= cap_req ? 10 : (cap_left > 0 ? cap_left - 1 : 0);
    sub_div  <= (sub_div == 5) ? 0 : sub_div + 1;
  end
  // sub clock runs free, period of six reference cycles, one driver only
  assign sub_clk_pin = (sub_div > 2);
  // both pins rest low between pulses
  assign ext_clock_pin     = (ext_left != 0);
  assign capture_input_pin = (cap_left != 0);
endmodule

// [sim/ptm_timer_tb.sv]
// ==========
// self-checking bench for the timer
module ptm_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  ptm_pkg::ptm_bus_req_type bus_req = '0;
  logic [7:0] bus_rdata;
  logic ext_req = 1'b0;
  logic cap_req = 1'b0;
  logic sub_clk_pin, ext_clock_pin, capture_input_pin;
  logic out_pin, out_comp, out_oe, flag_a, flag_p;
  logic [7:0] mreg [0:15] = '{default: 8'h00}; // committed register image
  logic [7:0] held [0:15] = '{default: 8'h00}; // low bytes not yet committed
  int divs [0:7] = '{4, 1, 16, 64, 6, 6, 1, 1}; // ticks per count per select
  int n_errors = 0;
  int checks = 0;
  always #10 ref_clk = ~ref_clk;
  ptm_timer dut (
    .ref_clk                 (ref_clk),
    .srst                    (srst),
    .bus_req                 (bus_req),
    .bus_rdata               (bus_rdata),
    .sub_clk_pin             (sub_clk_pin),
    .ext_clock_pin           (ext_clock_pin),
    .capture_input_pin       (capture_input_pin),
    .timer_output_pin        (out_pin),
    .timer_output_complement (out_comp),
    .timer_output_oe         (out_oe),
    .match_a_flag            (flag_a),
    .match_p_flag            (flag_p)
  );
  ptm_pin_model pins_model (
    .ref_clk           (ref_clk),
    .ext_req           (ext_req),
    .cap_req           (cap_req),
    .ext_clock_pin     (ext_clock_pin),
    .capture_input_pin (capture_input_pin),
    .sub_clk_pin       (sub_clk_pin)
  );
  // ==========
  // compare tasks, one per kind of result
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkr(input string nm, input int lo, input int hi, input logic [9:0] g);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========
  // register bus tasks; the model commits a pair on its high byte
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    case (a)
      4'h0: mreg[0] = d & 8'hf8;
      4'h1: mreg[1] = d;
      4'h4, 4'h6: held[a] = d;
      4'h5, 4'h7: begin
        mreg[a - 1] = held[a - 1];
        mreg[a] = d & 8'h03;
      end
      default: ;
    endcase
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    @(negedge ref_clk);
    d = bus_rdata;
  endtask
  task automatic rdcnt(output logic [9:0] v);
    logic [7:0] lo, hi;
    rd(4'h2, lo);
    rd(4'h3, hi);
    chk8("count_high_unused", 8'h00, hi & 8'hfc);
    v = {hi[1:0], lo};
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // stop first, then clear flags and load the setup
  task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
    wr(4'h0, 8'h00);
    wr(4'h8, 8'h03);
    wr(4'h1, c1);
    wr(4'h4, a[7:0]);
    wr(4'h5, {6'h00, a[9:8]});
    wr(4'h6, p[7:0]);
    wr(4'h7, {6'h00, p[9:8]});
  endtask
  task automatic go(input logic [2:0] sel, input logic hold);
    wr(4'h0, {hold, sel, 1'b1, 3'h0});
  endtask
  task automatic pulse(input logic on_ext);
    @(posedge ref_clk);
    ext_req <= on_ext;
    cap_req <= !on_ext;
    @(posedge ref_clk);
    ext_req <= 1'b0;
    cap_req <= 1'b0;
  endtask
  // watchdog: tests need well under twenty thousand cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    $display("watchdog expired");
    report_and_stop;
  end
  // ==========
  // main sequence
  initial begin
    logic [7:0] d;
    logic [9:0] v, v2;
    int want, act, fn, ini, inv, lim, per;
    lim = $urandom(94);
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 0; a < 10; a++) begin
      rd(a[3:0], d);
      chk8("reset_value", 8'h00, d);
    end
    for (int a = 0; a < 10; a++) begin
      d = 8'($urandom);
      wr(a[3:0], (a == 0) ? d & 8'hf7 : d); // run kept off
    end
    for (int a = 0; a < 10; a++) begin
      if (a < 2 || (a > 3 && a != 8)) begin
        rd(a[3:0], d);
        chk8("reg_readback", mreg[a], d);
      end
    end
    wr(4'h4, 8'h5a);
    rd(4'h4, d);
    chk8("low_before_high", mreg[4], d);
    wr(4'h5, 8'hff);
    rd(4'h4, d);
    chk8("pair_commit", 8'h5a, d);
    $display("test registers done");
    for (int sel = 0; sel < 8; sel++) begin
      cfg(8'hc0, 10'h000, 10'h000);
      go(sel[2:0], 1'b0);
      for (int i = 0; i < 8; i++) begin
        if (sel > 5) pulse(1'b1);
        cyc(18);
      end
      go(sel[2:0], 1'b1);
      rdcnt(v);
      // eight windows of 18 cycles give 144 counting cycles
      want = (sel > 5) ? 8 : 144 / divs[sel];
      chkr("clock_select_count", want > 4 ? want - 4 : 0, want + 6, v);
      chk1("oe_timer", 1'b0, out_oe);
    end
    cyc(10);
    rdcnt(v2);
    chk8("held_count", v[7:0], v2[7:0]);
    wr(4'h0, 8'h98); // new select while held, run stays on
    wr(4'h0, 8'h18);
    cyc(20);
    go(3'h1, 1'b1);
    rdcnt(v);
    chkr("resumed_count", v2 + 18, v2 + 28, v);
    wr(4'h0, 8'h10);
    wr(4'h2, 8'($urandom));
    wr(4'h3, 8'($urandom));
    cyc(10);
    rdcnt(v2);
    chk8("stopped_count", v[7:0], v2[7:0]);
    go(3'h1, 1'b1);
    rdcnt(v);
    chkr("restart_count", 0, 0, v);
    $display("test counter done");
    for (int clr = 0; clr < 2; clr++) begin
      lim = 20 + $urandom_range(20);
      per = 5 + $urandom_range(10);
      cfg(8'hc0 | 8'(clr), 10'(lim), 10'(per));
      go(3'h1, 1'b0);
      for (int i = 0; i < 6; i++) begin
        cyc($urandom_range(40));
        go(3'h1, 1'b1);
        rdcnt(v);
        chkr("count_limit", 0, (clr ? lim : per) - 1, v);
        go(3'h1, 1'b0);
      end
      chk1("flag_a", clr[0], flag_a);
      chk1("flag_p", !clr, flag_p);
      rd(4'h8, d);
      chk8("status", {6'h00, !clr[0], clr[0]}, d);
    end
    cfg(8'hc0, 10'h000, 10'h000);
    go(3'h1, 1'b0);
    cyc(1040);
    chk1("overflow_flag", 1'b1, flag_p);
    $display("test clearing done");
    for (int k = 0; k < 16; k++) begin
      fn = k % 4;
      ini = (k / 4) % 2;
      inv = k / 8;
      cfg({2'b00, fn[1:0], ini[0], inv[0], 2'b01}, 10'h008, 10'h000);
      go(3'h1, 1'b0);
      cyc(2);
      chk1("initial_level", ini[0] ^ inv[0], out_pin);
      chk1("oe_compare", 1'b1, out_oe);
      for (int i = 0; i < 40 && flag_a !== 1'b1; i++) cyc(1);
      cyc(2);
      act = (fn == 0) ? ini : (fn == 3) ? !ini : fn - 1;
      chk1("match_a_level", act[0] ^ inv[0], out_pin);
      chk1("complement", ~out_pin, out_comp);
      chk1("no_p_flag", 1'b0, flag_p);
    end
    cfg(8'h30, 10'h009, 10'h006);
    go(3'h1, 1'b0);
    cyc(30);
    chk1("p_match_pin", 1'b0, out_pin);
    chk1("p_flag_only", 1'b1, flag_p & !flag_a);
    $display("test compare output done");
    for (int k = 0; k < 8; k++) begin
      fn = k % 4;
      cfg({2'b01, fn[1:0], 2'b00, k[2], 1'b0}, 10'h000, 10'h000);
      go(3'h1, 1'b0);
      pulse(k[2]);
      cyc(6);
      chk1("capture_rise", fn == 0 || fn == 2, flag_a);
      wr(4'h8, 8'h03);
      cyc(12);
      chk1("capture_fall", fn == 1 || fn == 2, flag_a);
    end
    $display("test capture done");
    for (fn = 0; fn < 4; fn++) begin
      ini = $urandom_range(1);
      inv = $urandom_range(1);
      cfg({2'b10, fn[1:0], ini[0], inv[0], 2'b00}, 10'h005, 10'h014);
      if (fn == 3) begin
        wr(4'h0, 8'h10);
        pulse(1'b1);
      end else begin
        go(3'h1, 1'b0);
      end
      cyc(2);
      act = 0;
      for (int i = 0; i < 40; i++) begin
        cyc(1);
        act += (out_pin === (ini[0] ^ inv[0]));
      end
      want = (fn == 1) ? 40 : (fn == 2) ? 10 : (fn == 3) ? 5 : 0;
      chkr("active_cycles", want > 3 ? want - 3 : 0, want + 3, 10'(act));
      chk1("oe_pwm", 1'b1, out_oe);
    end
    $display("test pwm done");
    report_and_stop;
  end
endmodule
